// ===== hw/sdamp_pkg.sv
// Package: constants and mode enumeration for the step input and amplifier drive block
package sdamp_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // Carrier 19.53 KHz: 512 ticks of 10 MHz gives 19.53 KHz
   localparam real PWM_CARRIER_KHZ = 19.53;
   localparam int unsigned PWM_PERIOD_CYC = int'(real'(CLK_HZ) / (PWM_CARRIER_KHZ * 1000.0)) & ~1;
   // Servo tick 1.953 KHz, rounded down to whole cycles
   localparam real SERVO_TICK_KHZ = 1.953;
   localparam int unsigned SERVO_TICK_CYC = int'($floor(real'(CLK_HZ) / (SERVO_TICK_KHZ * 1000.0)));
   localparam int unsigned POS_W = 32;
   localparam int unsigned VEL_W = 32;
   localparam int unsigned VEL_FRAC_W = 16;
   localparam int unsigned STEP_CNT_W = 16;
   localparam int unsigned MULT_W = 16;
   localparam int unsigned DUTY_W = 10;
   localparam int unsigned MAG_W = 8;
   localparam int unsigned DUTY_EXT_W = 2;
   localparam logic [9:0] DUTY_HALF = 10'h200;
   typedef enum logic [1:0] {
      SDAMP_MODE_PWM_DIR,
      SDAMP_MODE_ANTIPHASE,
      SDAMP_MODE_THREE_PHASE
   } sdamp_mode_e;
endpackage : sdamp_pkg

// ===== hw/sdamp_commut.sv
// Hall commutation lookup for three-phase drive
`timescale 1ns/10ps
`default_nettype none
module sdamp_commut (
   input wire logic [2:0] hall_in,
   input wire logic reverse_in,
   output logic [2:0] chop_sel_out,
   output logic [2:0] en_out
);
   // Bit 2 is bridge a, bit 0 is bridge c; hall bit 2 is sensor a
   always_comb begin
      chop_sel_out = 3'h4;
      en_out = 3'h6;
      if (!reverse_in) begin
         case (hall_in)
            3'b100: begin chop_sel_out = 3'h4; en_out = 3'h5; end
            3'b110: begin chop_sel_out = 3'h2; en_out = 3'h3; end
            3'b010: begin chop_sel_out = 3'h2; en_out = 3'h6; end
            3'b011: begin chop_sel_out = 3'h1; en_out = 3'h5; end
            3'b001: begin chop_sel_out = 3'h1; en_out = 3'h3; end
            3'b101: begin chop_sel_out = 3'h4; en_out = 3'h6; end
            default: begin chop_sel_out = 3'h4; en_out = 3'h6; end
         endcase
      end else begin
         case (hall_in)
            3'b101: begin chop_sel_out = 3'h2; en_out = 3'h6; end
            3'b001: begin chop_sel_out = 3'h2; en_out = 3'h3; end
            3'b011: begin chop_sel_out = 3'h4; en_out = 3'h5; end
            3'b010: begin chop_sel_out = 3'h4; en_out = 3'h6; end
            3'b110: begin chop_sel_out = 3'h1; en_out = 3'h3; end
            3'b100: begin chop_sel_out = 3'h1; en_out = 3'h5; end
            default: begin chop_sel_out = 3'h2; en_out = 3'h6; end
         endcase
      end
   end
endmodule : sdamp_commut
`default_nettype wire

// ===== hw/sdamp_top.sv
// Step and direction accumulator with amplifier drive generator
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Each step pulse counts up when direction is 0, down when 1.
// - Each servo tick, step count times multiplier is added to command position.
// - Step input works only when enabled; host avoids limit functions then.
// - Step adjustments add on top of the profiled command position.
// - Fault output high on servo fault, only in step mode.
// - Stand-alone start drives fault output low once ready.
// - Velocity and acceleration are 32 bits with 16 fraction bits.
// - Position is signed 32-bit whole counts.
// - Output mode resets to PWM and direction unless stored option says otherwise.
// - PWM mode: chop a carries 19.53 KHz active-high duty from magnitude.
// - PWM duty is 10 bits: 8-bit magnitude plus two low bits.
// - Drive sign is 0 forward, 1 reverse, in antiphase too.
// - Bridge enable a is active high.
// - Antiphase: zero is 50%, full negative 0%, full positive 100%.
// - Three-phase: halls choose chopping output and enables, forward and reverse tables.
// - Halls all high or low: first two bridges act as H-bridge.
// - Three-phase: exactly two bridge enables active.
// - One enabled bridge chops, the other holds its chop low.
// - Stored antiphase or three-phase selection reapplies after any reset.
// - Servo tick repeats at 1.953 KHz.
module sdamp_top #(
   parameter int unsigned STEP_CNT_W = sdamp_pkg::STEP_CNT_W,
   parameter int unsigned MULT_W = sdamp_pkg::MULT_W,
   parameter int unsigned SERVO_TICK_CYC = sdamp_pkg::SERVO_TICK_CYC
) (
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire logic master_reset_in,
   input wire logic soft_reset_in,
   input wire logic step_pulse_in,
   input wire logic step_direction_in,
   input wire logic step_mode_en_in,
   input wire logic [MULT_W-1:0] step_mult_in,
   input wire logic signed [31:0] profile_vel_in,
   input wire logic profile_run_in,
   input wire logic servo_fault_in,
   input wire logic standalone_cfg_in,
   input wire logic [1:0] stored_mode_in,
   input wire logic mode_wr_in,
   input wire logic [1:0] mode_sel_in,
   input wire logic signed [8:0] filter_out_in,
   input wire logic [1:0] filter_ext_in,
   input wire logic amp_en_in,
   input wire logic hall_sense_a,
   input wire logic hall_sense_b,
   input wire logic hall_sense_c,
   output logic signed [31:0] cmd_pos_out,
   output logic servo_tick_out,
   output logic fault_out,
   output logic drive_sign_out,
   output logic chop_out_a,
   output logic chop_out_b,
   output logic chop_out_c,
   output logic bridge_en_a,
   output logic bridge_en_b,
   output logic bridge_en_c
);
   localparam int unsigned TICK_W = $clog2(SERVO_TICK_CYC);
   localparam int unsigned PWM_W = $clog2(sdamp_pkg::PWM_PERIOD_CYC);
   localparam logic [1:0] MODE_PWM = 2'(sdamp_pkg::SDAMP_MODE_PWM_DIR);
   localparam logic [1:0] MODE_ANTI = 2'(sdamp_pkg::SDAMP_MODE_ANTIPHASE);
   localparam logic [1:0] MODE_3PH = 2'(sdamp_pkg::SDAMP_MODE_THREE_PHASE);

   // Internal run gate: master reset low disables step counting and the chop and bridge enable outputs
   logic run;
   assign run = master_reset_in;

   // Servo tick and step accumulation state
   logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;
   logic step_prev_q, step_prev_d;
   logic signed [STEP_CNT_W-1:0] step_cnt_q, step_cnt_d;
   logic signed [31:0] pos_q, pos_d;
   logic signed [31:0] vel_acc_q, vel_acc_d;
   logic signed [STEP_CNT_W+MULT_W:0] step_prod;
   logic step_edge;
   logic signed [STEP_CNT_W-1:0] step_inc;

   assign step_edge = step_pulse_in & ~step_prev_q;
   assign step_prod = step_cnt_q * $signed({1'b0, step_mult_in});

   always_comb begin
      tick_cnt_d = tick_cnt_q + 1'b1;
      tick_d = 1'b0;
      step_prev_d = step_pulse_in;
      step_inc = '0;
      pos_d = pos_q;
      vel_acc_d = vel_acc_q;
      if (tick_cnt_q == TICK_W'(SERVO_TICK_CYC - 1)) begin
         tick_cnt_d = '0;
         tick_d = 1'b1;
      end
      if (step_edge && step_mode_en_in) begin
         step_inc = step_direction_in ? -STEP_CNT_W'(1) : STEP_CNT_W'(1);
      end
      step_cnt_d = step_cnt_q + step_inc;
      if (tick_q) begin
         // Fractional velocity: the low 16 bits carry sub-count remainder
         vel_acc_d = profile_run_in ? 32'(vel_acc_q[15:0]) + profile_vel_in
                                    : 32'(vel_acc_q[15:0]);
         // Profile and step terms sum, so steps ride on the profile
         pos_d = pos_q + (profile_run_in ? 32'(vel_acc_d >>> 16) : 32'h0)
                 + 32'(step_prod);
         // New pulses in the apply cycle survive the clear
         step_cnt_d = step_inc;
      end
      if (!run) begin
         step_cnt_d = '0;
         vel_acc_d = '0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
         step_prev_q <= 1'b0;
         step_cnt_q <= '0;
         pos_q <= '0;
         vel_acc_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
         step_prev_q <= step_prev_d;
         step_cnt_q <= step_cnt_d;
         pos_q <= pos_d;
         vel_acc_q <= vel_acc_d;
      end
   end

   // Output mode, fault flag and ready state
   logic [1:0] mode_q, mode_d;
   logic fault_q, fault_d;
   logic ready_q, ready_d;
   logic stored_valid;
   assign stored_valid = (stored_mode_in == MODE_ANTI) || (stored_mode_in == MODE_3PH);

   always_comb begin
      mode_d = mode_q;
      ready_d = 1'b1;
      fault_d = fault_q;
      // Async reset may only load constants, so the stored option lands on the first edge after
      if (soft_reset_in || !run || !ready_q) begin
         mode_d = stored_valid ? stored_mode_in : MODE_PWM;
      end else if (mode_wr_in) begin
         mode_d = (mode_sel_in == MODE_ANTI || mode_sel_in == MODE_3PH) ? mode_sel_in : MODE_PWM;
      end
      if (!run) begin
         // Held high until ready when starting stand-alone
         fault_d = standalone_cfg_in;
         ready_d = 1'b0;
      end else if (step_mode_en_in && servo_fault_in) begin
         fault_d = 1'b1;
      end else if (!step_mode_en_in) begin
         fault_d = 1'b0;
      end else if (ready_q) begin
         fault_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode_q <= MODE_PWM;
         fault_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         fault_q <= fault_d;
         ready_q <= ready_d;
      end
   end

   // PWM carrier counter, restarts while disabled
   logic [PWM_W-1:0] pwm_cnt_q, pwm_cnt_d;
   always_comb begin
      pwm_cnt_d = pwm_cnt_q + 1'b1;
      if (pwm_cnt_q == PWM_W'(sdamp_pkg::PWM_PERIOD_CYC - 1) || !run) begin
         pwm_cnt_d = '0;
      end
   end
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pwm_cnt_q <= '0;
      end else begin
         pwm_cnt_q <= pwm_cnt_d;
      end
   end

   // Duty computation: magnitude with two extra low bits
   logic neg;
   logic [7:0] mag;
   logic [9:0] duty_mag, duty_anti, duty;
   logic pwm_raw;
   logic [2:0] chop_sel, en3;
   logic [2:0] halls;
   assign halls = {hall_sense_a, hall_sense_b, hall_sense_c};
   assign neg = filter_out_in[8];
   assign mag = neg ? 8'(-filter_out_in) : filter_out_in[7:0];
   assign duty_mag = {mag, filter_ext_in};
   // Signed 10-bit around midpoint; full positive saturates to constant high
   assign duty_anti = neg ? sdamp_pkg::DUTY_HALF - {1'b0, duty_mag[9:1]}
                          : sdamp_pkg::DUTY_HALF + {1'b0, duty_mag[9:1]};
   assign duty = (mode_q == MODE_ANTI) ? duty_anti : duty_mag;
   // Carrier is 512 steps so a 10-bit duty maps two steps per tick, dropping its low bit
   assign pwm_raw = ((mode_q == MODE_ANTI) && !neg && duty_mag == 10'h3ff) ? 1'b1
                    : ({1'b0, pwm_cnt_q} < (PWM_W + 1)'(duty >> (10 - PWM_W)));

   sdamp_commut u_commut (
      .hall_in(halls),
      .reverse_in(neg),
      .chop_sel_out(chop_sel),
      .en_out(en3)
   );

   logic [2:0] chop_q, chop_d, en_q, en_d;
   logic sign_q, sign_d;
   always_comb begin
      sign_d = neg;
      chop_d = 3'h0;
      en_d = 3'h0;
      case (mode_q)
         MODE_3PH: begin
            // Lookup guarantees two enables, one chopping, the other held low
            chop_d = chop_sel & {3{pwm_raw}};
            en_d = amp_en_in ? en3 : 3'h0;
         end
         default: begin
            chop_d = {pwm_raw, 2'b00};
            en_d = {amp_en_in, 2'b00};
         end
      endcase
      if (!run) begin
         chop_d = 3'h0;
         en_d = 3'h0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         chop_q <= 3'h0;
         en_q <= 3'h0;
         sign_q <= 1'b0;
      end else begin
         chop_q <= chop_d;
         en_q <= en_d;
         sign_q <= sign_d;
      end
   end

   assign cmd_pos_out = pos_q;
   assign servo_tick_out = tick_q;
   assign fault_out = fault_q;
   assign drive_sign_out = sign_q;
   assign {chop_out_a, chop_out_b, chop_out_c} = chop_q;
   assign {bridge_en_a, bridge_en_b, bridge_en_c} = en_q;

   property p_step_up;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      step_edge && step_mode_en_in && !step_direction_in && !tick_q && run
      |=> step_cnt_q == $past(step_cnt_q) + 1;
   endproperty
   a_step_up: assert property (p_step_up) else $error("step count did not rise");
   property p_apply;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      tick_q && !profile_run_in |=> pos_q == $past(pos_q) + 32'($past(step_prod));
   endproperty
   a_apply: assert property (p_apply) else $error("scaled steps not added");
   property p_clear;
      @(posedge ref_clk_in) disable iff (!arst_n_in) tick_q && !step_edge |=> step_cnt_q == 0;
   endproperty
   a_clear: assert property (p_clear) else $error("step count not cleared");
   property p_nostep;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      !step_mode_en_in && !tick_q && run |=> step_cnt_q == $past(step_cnt_q);
   endproperty
   a_nostep: assert property (p_nostep) else $error("step counted while disabled");
   property p_fault;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      run && step_mode_en_in && servo_fault_in |=> fault_out;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not reported");
   property p_fault_off;
      @(posedge ref_clk_in) disable iff (!arst_n_in) run && !step_mode_en_in |=> !fault_out;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault outside step mode");
   property p_two_en;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      mode_q == MODE_3PH && $past(amp_en_in) && $past(run) && $past(mode_q) == MODE_3PH
      |-> $countones(en_q) == 2;
   endproperty
   a_two_en: assert property (p_two_en) else $error("enable count wrong");
   property p_en_a;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      run && mode_q != MODE_3PH |=> bridge_en_a == $past(amp_en_in);
   endproperty
   a_en_a: assert property (p_en_a) else $error("bridge enable a mismatch");
   property p_sign;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      1'b1 |=> drive_sign_out == $past(filter_out_in[8]);
   endproperty
   a_sign: assert property (p_sign) else $error("drive sign wrong");
   property p_tick;
      @(posedge ref_clk_in) disable iff (!arst_n_in) tick_q |=> !tick_q [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("servo tick too close");
   property p_mode_rst;
      @(posedge ref_clk_in) disable iff (!arst_n_in)
      soft_reset_in && !stored_valid |=> mode_q == MODE_PWM;
   endproperty
   a_mode_rst: assert property (p_mode_rst) else $error("mode not default");

   c_step: cover property (@(posedge ref_clk_in) step_edge && step_mode_en_in);
   c_apply: cover property (@(posedge ref_clk_in) tick_q && step_cnt_q != 0);
   c_3ph: cover property (@(posedge ref_clk_in) mode_q == MODE_3PH && |chop_q);
   c_fault: cover property (@(posedge ref_clk_in) fault_out);
endmodule : sdamp_top
`default_nettype wire

// ===== dv/sdamp_indexer.sv
// Indexing system model: step pulses, direction line and master reset pin
`timescale 1ns/10ps
`default_nettype none
module sdamp_indexer (
   input wire logic clk_in,
   output logic step_pulse_out,
   output logic step_dir_out,
   output logic master_reset_out
);
   initial begin
      step_pulse_out = 1'b0;
      step_dir_out = 1'b0;
      master_reset_out = 1'b0;
   end
   // Low holds the controller disabled, high lets it run
   task automatic run(input logic en);
      @(posedge clk_in);
      master_reset_out <= en;
   endtask : run
   // Two-cycle pulses; direction held 63 cycles past the last rise
   task automatic burst(input int n, input logic dir);
      @(posedge clk_in);
      step_dir_out <= dir;
      repeat (n) begin
         @(posedge clk_in);
         step_pulse_out <= 1'b1;
         repeat (2) @(posedge clk_in);
         step_pulse_out <= 1'b0;
         @(posedge clk_in);
      end
      repeat (60) @(posedge clk_in);
      // Hold time over: show the opposite level, not a stale one
      step_dir_out <= ~dir;
   endtask : burst
endmodule : sdamp_indexer
`default_nettype wire

// ===== dv/test_sdamp_top.sv
// Self-checking bench for the step input and amplifier drive block
`timescale 1ns/10ps
`default_nettype none
module test_sdamp_top;
   localparam int TICK = 16;
   localparam int LIMIT = 60000;
   logic ref_clk_in, arst_n_in, soft_reset_in, step_mode_en_in, profile_run_in;
   logic servo_fault_in, standalone_cfg_in, mode_wr_in, amp_en_in;
   logic master_reset_in, step_pulse_in, step_direction_in;
   logic [15:0] step_mult_in;
   logic signed [31:0] profile_vel_in, cmd_pos_out;
   logic [1:0] stored_mode_in, mode_sel_in, filter_ext_in;
   logic signed [8:0] filter_out_in;
   logic [2:0] hall;
   logic servo_tick_out, fault_out, drive_sign_out;
   logic chop_out_a, chop_out_b, chop_out_c, bridge_en_a, bridge_en_b, bridge_en_c;
   int miscompares, samples_checked, seed, cycles, last_tick, gap, exp_steps, prof_acc;
   int hi[6];
   int f, e;
   logic [2:0] ch;
   logic [2:0] fwd_ch[8] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b100, 3'b100, 3'b010, 3'b100};
   logic [2:0] rev_ch[8] = '{3'b010, 3'b010, 3'b100, 3'b100, 3'b001, 3'b010, 3'b001, 3'b010};
   logic [2:0] en_tab[8] = '{3'b110, 3'b011, 3'b110, 3'b101, 3'b101, 3'b110, 3'b011, 3'b110};

   sdamp_indexer u_idx (.clk_in(ref_clk_in), .step_pulse_out(step_pulse_in),
      .step_dir_out(step_direction_in), .master_reset_out(master_reset_in));

   sdamp_top #(.SERVO_TICK_CYC(TICK)) u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .master_reset_in(master_reset_in), .soft_reset_in(soft_reset_in),
      .step_pulse_in(step_pulse_in), .step_direction_in(step_direction_in),
      .step_mode_en_in(step_mode_en_in), .step_mult_in(step_mult_in),
      .profile_vel_in(profile_vel_in), .profile_run_in(profile_run_in),
      .servo_fault_in(servo_fault_in), .standalone_cfg_in(standalone_cfg_in),
      .stored_mode_in(stored_mode_in), .mode_wr_in(mode_wr_in), .mode_sel_in(mode_sel_in),
      .filter_out_in(filter_out_in), .filter_ext_in(filter_ext_in), .amp_en_in(amp_en_in),
      .hall_sense_a(hall[2]), .hall_sense_b(hall[1]), .hall_sense_c(hall[0]),
      .cmd_pos_out(cmd_pos_out), .servo_tick_out(servo_tick_out), .fault_out(fault_out),
      .drive_sign_out(drive_sign_out), .chop_out_a(chop_out_a), .chop_out_b(chop_out_b),
      .chop_out_c(chop_out_c), .bridge_en_a(bridge_en_a), .bridge_en_b(bridge_en_b),
      .bridge_en_c(bridge_en_c));

   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   // Profile share of the position model, and tick spacing
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (servo_tick_out === 1'b1) begin
         gap <= cycles - last_tick;
         last_tick <= cycles;
         if (profile_run_in) prof_acc <= prof_acc + (profile_vel_in >>> 16);
      end
      if (cycles == LIMIT) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk

   function automatic int duty(input int fv, input int ev);
      return (((fv < 0 ? -fv : fv) << 2) | ev) >> 1;
   endfunction : duty

   task automatic clk(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : clk

   task automatic steps(input int n, input logic dir);
      u_idx.burst(n, dir);
      exp_steps += (dir ? -n : n) * int'(step_mult_in);
   endtask : steps

   task automatic mode(input sdamp_pkg::sdamp_mode_e m);
      @(posedge ref_clk_in);
      mode_sel_in <= m;
      mode_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      mode_wr_in <= 1'b0;
   endtask : mode

   // Waits over a full carrier period first so the 512-cycle window sees only the new duty
   task automatic measure(input int fv, input int ev);
      logic [5:0] v;
      @(posedge ref_clk_in);
      filter_out_in <= 9'(fv);
      filter_ext_in <= 2'(ev);
      clk(520);
      hi = '{default: 0};
      repeat (512) begin
         @(posedge ref_clk_in);
         v = {chop_out_a, chop_out_b, chop_out_c, bridge_en_a, bridge_en_b, bridge_en_c};
         for (int i = 0; i < 6; i++) hi[i] += (v[5-i] === 1'b1);
      end
   endtask : measure

   initial begin
      seed = 23;
      {arst_n_in, soft_reset_in, step_mode_en_in, profile_run_in, servo_fault_in} = '0;
      {standalone_cfg_in, mode_wr_in, amp_en_in, stored_mode_in, mode_sel_in} = '0;
      {step_mult_in, profile_vel_in, filter_out_in, filter_ext_in, hall} = '0;
      {miscompares, samples_checked, cycles, last_tick, gap, exp_steps, prof_acc} = '0;
      clk(8);
      arst_n_in <= 1'b1;
      u_idx.run(1'b1);
      step_mode_en_in <= 1'b1;
      step_mult_in <= 16'(1 + ($random(seed) & 15));
      steps(8, 1'b1);
      repeat (4) steps(1 + ($random(seed) & 7), 1'($random(seed) & 1));
      clk(4 * TICK);
      chk(cmd_pos_out, exp_steps + prof_acc, "step position");
      chk(gap, TICK, "servo tick spacing");
      @(posedge servo_tick_out);
      clk(3);
      profile_vel_in <= 32'sh0003_0000;
      profile_run_in <= 1'b1;
      steps(5, 1'b0);
      @(posedge servo_tick_out);
      clk(3);
      profile_run_in <= 1'b0;
      clk(4 * TICK);
      chk(cmd_pos_out, exp_steps + prof_acc, "profile plus steps");
      step_mode_en_in <= 1'b0;
      u_idx.burst(6, 1'b0);
      clk(4 * TICK);
      chk(cmd_pos_out, exp_steps + prof_acc, "steps while disabled");
      step_mode_en_in <= 1'b1;
      u_idx.run(1'b0);
      u_idx.burst(6, 1'b0);
      clk(4 * TICK);
      chk(cmd_pos_out, exp_steps + prof_acc, "steps in master reset");
      u_idx.run(1'b1);
      $display("test steps done");
      servo_fault_in <= 1'b1;
      clk(3);
      chk(fault_out, 1, "fault in step mode");
      step_mode_en_in <= 1'b0;
      clk(3);
      chk(fault_out, 0, "fault outside step mode");
      servo_fault_in <= 1'b0;
      standalone_cfg_in <= 1'b1;
      step_mode_en_in <= 1'b1;
      u_idx.run(1'b0);
      clk(3);
      chk(fault_out, 1, "stand-alone not ready");
      u_idx.run(1'b1);
      clk(3);
      chk(fault_out, 0, "stand-alone ready");
      standalone_cfg_in <= 1'b0;
      $display("test fault done");
      mode(sdamp_pkg::SDAMP_MODE_PWM_DIR);
      amp_en_in <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         f = (i == 4) ? 255 : $random(seed) % 256;
         e = $random(seed) & 3;
         measure(f, e);
         chk(hi[0], duty(f, e), "pwm duty");
         chk(drive_sign_out, f < 0, "drive sign");
         chk(hi[3], 512, "bridge enable on");
      end
      amp_en_in <= 1'b0;
      measure(100, 0);
      chk(hi[3], 0, "bridge enable off");
      mode(sdamp_pkg::SDAMP_MODE_ANTIPHASE);
      measure(0, 0);
      chk(hi[0], 256, "antiphase zero");
      measure(255, 3);
      chk(hi[0], 512, "antiphase full positive");
      measure(-255, 3);
      chk(hi[0], 0, "antiphase full negative");
      chk(drive_sign_out, 1, "antiphase sign");
      $display("test pwm done");
      mode(sdamp_pkg::SDAMP_MODE_THREE_PHASE);
      amp_en_in <= 1'b1;
      for (int h = 0; h < 16; h++) begin
         hall <= 3'(h);
         ch = h[3] ? rev_ch[h & 7] : fwd_ch[h & 7];
         measure(h[3] ? -200 : 200, 0);
         for (int k = 0; k < 3; k++) begin
            chk(hi[k], ch[2-k] ? 400 : 0, "phase chop");
            chk(hi[k+3], en_tab[h & 7][2-k] ? 512 : 0, "phase enable");
         end
      end
      $display("test three phase done");
      amp_en_in <= 1'b0;
      stored_mode_in <= 2'h1;
      soft_reset_in <= 1'b1;
      clk(1);
      soft_reset_in <= 1'b0;
      measure(0, 0);
      chk(hi[0], 256, "stored mode after soft reset");
      arst_n_in <= 1'b0;
      clk(2);
      arst_n_in <= 1'b1;
      measure(0, 0);
      chk(hi[0], 256, "stored mode after reset");
      stored_mode_in <= 2'h0;
      arst_n_in <= 1'b0;
      clk(2);
      arst_n_in <= 1'b1;
      measure(0, 0);
      chk(hi[0], 0, "default mode after reset");
      $display("test stored mode done");
      complete_run();
   end
endmodule : test_sdamp_top
`default_nettype wire
